// ### inc/far_consts.svh
// Constants for the fault supervision and auto-retry block
//
// Contract
// - Logic-supply loss with enable set enters fail-safe, clears registers, uses direct inputs.
// - Open-load and output-short detections only set flags; each has a disable.
// - Supply undervoltage leaves the serial registers accessible and undisturbed.
// - Supply rise after low period, other supply low, sets power-on flag bit 6.
// - Transition into wake with a supply up also sets the power-on flag.
// - Retry condition is over-current, severe short, over-temperature or undervoltage.
// - Undervoltage and over-temperature retries wait until the cause disappears.
// - With auto-retry disabled, a latchable fault latches the channel off at once.
// - Auto-retry is enabled exactly when retry-select equals the load-type input.
// - A retry sequence starts when fault_control is set and retry condition holds.
// - Channel switches on again after the retry period selected by bits 3:2.
// - Fault gone before exhaustion resumes normal operation, fault bit stays set.
// - Unlimited retry keeps retrying and never latches the channel off.
// - After 15 counted retries set exhausted bit, allow one more, then latch.
// - Delatch turns channel on during retrying without changing the counter.
// - Retry counter reads back in bits 7:4 of the channel config word.
// - Counter clears on fail-safe, wake, power-on, unlimited set, retry disable.
// - Latched channel cleared by unlimited set retries after one period if enabled.
// - Lamp restarts duration counter each retry; motor at first clean period end.
// - Off-state short to supply shows live on fault output, sticky until read.
// - Off-state open load shows live on fault output, sticky until read.
// - Latched fault bits clear on read once cause gone and channel delatched.
`ifndef FAR_CONSTS_SVH
`define FAR_CONSTS_SVH

// Register byte offsets
`define FAR_ADDR_GEN     32'h0000_0000
`define FAR_ADDR_CH0     32'h0000_0008
`define FAR_ADDR_CH1     32'h0000_000C
`define FAR_ADDR_STAT    32'h0000_0010
`define FAR_ADDR_FLT     32'h0000_0014

// Channel config fields
`define FAR_CFG_RSEL     0
`define FAR_CFG_UNL      1
`define FAR_CFG_PER_LO   2
`define FAR_CFG_OS_DIS   6
`define FAR_CFG_OLF_DIS  7
`define FAR_CFG_OLN_DIS  8
`define FAR_CFG_DELATCH  9
`define FAR_CFG_RD_DIS   16

// Status and fault fields
`define FAR_ST_RFULL0    4
`define FAR_ST_POR       6
`define FAR_FLT_CH_W     8
`define FAR_FLT_UV       16

// Retry counter and timing
`define FAR_CNT_MAX      4'hF
`define FAR_TMR_W        24
`define FAR_CLK_MHZ      100
`define FAR_RETRY_T0_MS  10
`define FAR_RETRY_T1_MS  20
`define FAR_RETRY_T2_MS  40
`define FAR_RETRY_T3_MS  80

// Bus responses
`define FAR_RESP_OKAY    2'b00
`define FAR_RESP_SLVERR  2'b10

`endif

// ### inc/far_pkg.sv
// Types of the fault supervision and auto-retry block
package far_pkg;
`include "far_consts.svh"

	typedef enum logic [2:0] {
		FAR_ON    = 3'b001,
		FAR_WAIT  = 3'b010,
		FAR_LATCH = 3'b100
	} far_rstate_t;

	typedef enum logic [2:0] {
		FAR_SEL_NONE, FAR_SEL_GEN, FAR_SEL_CH0, FAR_SEL_CH1,
		FAR_SEL_STAT, FAR_SEL_FLT
	} far_sel_t;

	typedef struct packed {
		far_rstate_t              state;
		logic                     retry_sel;
		logic                     unlimited;
		logic [1:0]               period;
		logic                     os_dis;
		logic                     open_load_off_flag_dis;
		logic                     open_load_on_flag_dis;
		logic [3:0]               cnt;
		logic                     rfull;
		logic                     final_used;
		logic                     fault_control;
		logic [`FAR_TMR_W-1:0]    timer;
		logic                     oc;
		logic                     sc;
		logic                     ot;
		logic                     os;
		logic                     open_load_off_flag;
		logic                     open_load_on_flag;
		logic                     restart_pending;
		logic                     oc_in_period;
	} far_chan_t;

	typedef struct packed {
		far_chan_t [1:0]          chan;
		logic                     uv;
		logic                     por;
		logic                     supply_loss_en;
		logic                     fail_safe;
		logic                     asleep;
		logic                     vpwr_prev;
		logic                     vdd_prev;
		logic [1:0]               chan_on;
		logic [1:0]               restart;
		logic                     fsb_n;
		logic                     aw_got;
		logic                     w_got;
		logic [31:0]              awaddr;
		logic [31:0]              wdata;
		logic [3:0]               wstrb;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [31:0]              rdata;
		logic [1:0]               rresp;
	} far_state_t;

	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} far_axi_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} far_axi_rsp_t;

endpackage : far_pkg

// ### core/far_core.sv
// Fault supervision, auto-retry and off-state diagnostics for two channels
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`include "far_consts.svh"
module far_core #(
	parameter logic [23:0] RETRY_CYC0 =
		24'(`FAR_RETRY_T0_MS * 1000 * `FAR_CLK_MHZ),
	parameter logic [23:0] RETRY_CYC1 =
		24'(`FAR_RETRY_T1_MS * 1000 * `FAR_CLK_MHZ),
	parameter logic [23:0] RETRY_CYC2 =
		24'(`FAR_RETRY_T2_MS * 1000 * `FAR_CLK_MHZ),
	parameter logic [23:0] RETRY_CYC3 =
		24'(`FAR_RETRY_T3_MS * 1000 * `FAR_CLK_MHZ)
) (
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	// Register bus
	input  far_pkg::far_axi_req_t axi_req,
	output far_pkg::far_axi_rsp_t axi_rsp,
	// Supplies and wake
	input  wire logic             logic_supply_fail,
	input  wire logic             vpwr_above_por,
	input  wire logic             vdd_above_por,
	input  wire logic             wake_reset_n,
	input  wire logic             under_voltage,
	// Channel inputs
	input  wire logic [1:0]       direct_in,
	input  wire logic [1:0]       channel_request,
	input  wire logic [1:0]       load_type_select,
	input  wire logic [1:0]       over_current,
	input  wire logic [1:0]       severe_short,
	input  wire logic [1:0]       over_temperature,
	input  wire logic [1:0]       open_load_on_det,
	input  wire logic [1:0]       out_above_short_thr,
	input  wire logic [1:0]       out_above_openload_thr,
	input  wire logic [1:0]       pwm_period_end,
	// Channel outputs
	output logic [1:0]            channel_on,
	output logic [1:0]            oc_duration_restart,
	output logic                  fault_status_n,
	output logic                  fail_safe
);
	import far_pkg::*;

	localparam far_chan_t  CH_RST = '{state: FAR_ON, default: '0};
	localparam far_state_t ST_RST =
		'{chan: '{CH_RST, CH_RST}, fsb_n: 1'b1, default: '0};

	far_state_t st_ff;
	far_state_t nxt_st;
	logic       [1:0] rcond_w;
	logic       [1:0] hold_w;
	logic       [1:0] en_w;
	logic       [1:0] clr_w;
	logic       [1:0] delatch_w;
	logic             asleep_w;
	logic             wake_evt_w;
	logic             por_evt_w;
	logic             fs_entry_w;
	logic             aw_take;
	logic             w_take;
	logic             ar_take;
	logic             wr_do;
	far_sel_t         wsel;
	far_sel_t         rsel;

	// Address decode shared by the write and read paths
	function automatic far_sel_t far_dec(logic [31:0] a);
		case (a)
			`FAR_ADDR_GEN:  far_dec = FAR_SEL_GEN;
			`FAR_ADDR_CH0:  far_dec = FAR_SEL_CH0;
			`FAR_ADDR_CH1:  far_dec = FAR_SEL_CH1;
			`FAR_ADDR_STAT: far_dec = FAR_SEL_STAT;
			`FAR_ADDR_FLT:  far_dec = FAR_SEL_FLT;
			default:        far_dec = FAR_SEL_NONE;
		endcase
	endfunction : far_dec

	// Retry period in cycles for a period select value
	function automatic logic [23:0] far_period(logic [1:0] p);
		case (p)
			2'b00:   far_period = RETRY_CYC0;
			2'b01:   far_period = RETRY_CYC1;
			2'b10:   far_period = RETRY_CYC2;
			default: far_period = RETRY_CYC3;
		endcase
	endfunction : far_period

	// Read word assembly
	function automatic logic [31:0] far_rd(far_state_t s, far_sel_t sel);
		logic [31:0] r;
		far_chan_t   c;
		r = '0;
		c = (sel == FAR_SEL_CH1) ? s.chan[1] : s.chan[0];
		case (sel)
			FAR_SEL_GEN: r[0] = s.supply_loss_en;
			FAR_SEL_CH0, FAR_SEL_CH1: begin
				r[3:0] = {c.period, c.unlimited, c.retry_sel};
				r[7:4] = c.cnt;
				r[`FAR_CFG_RD_DIS +: 3] = {c.open_load_on_flag_dis, c.open_load_off_flag_dis, c.os_dis};
			end
			FAR_SEL_STAT: begin
				r[1:0] = {s.chan[1].state == FAR_LATCH,
					s.chan[0].state == FAR_LATCH};
				r[`FAR_ST_RFULL0 +: 2] = {s.chan[1].rfull, s.chan[0].rfull};
				r[`FAR_ST_POR] = s.por;
			end
			FAR_SEL_FLT: begin
				for (int k = 0; k < 2; k++) begin
					r[k*`FAR_FLT_CH_W +: 6] = {s.chan[k].open_load_on_flag, s.chan[k].open_load_off_flag,
						s.chan[k].os, s.chan[k].ot, s.chan[k].sc, s.chan[k].oc};
				end
				r[`FAR_FLT_UV] = s.uv;
			end
			default: r = '0;
		endcase
		far_rd = r;
	endfunction : far_rd

	// Bus handshakes and decoded requests
	assign aw_take = axi_req.awvalid && !st_ff.aw_got && !st_ff.bvalid;
	assign w_take  = axi_req.wvalid && !st_ff.w_got && !st_ff.bvalid;
	assign ar_take = axi_req.arvalid && !st_ff.rvalid;
	assign wr_do   = st_ff.aw_got && st_ff.w_got;
	assign wsel    = far_dec(st_ff.awaddr);
	assign rsel    = far_dec(axi_req.araddr);

	// Supply and wake events
	assign asleep_w   = !wake_reset_n && (direct_in == 2'b00);
	assign wake_evt_w = st_ff.asleep && !asleep_w;
	assign por_evt_w  = (vpwr_above_por && !st_ff.vpwr_prev &&
		!vdd_above_por && !st_ff.vdd_prev) ||
		(vdd_above_por && !st_ff.vdd_prev &&
		!vpwr_above_por && !st_ff.vpwr_prev) ||
		(wake_evt_w && ((vpwr_above_por && st_ff.vpwr_prev) ||
		(vdd_above_por && st_ff.vdd_prev)));
	assign fs_entry_w = logic_supply_fail && st_ff.supply_loss_en &&
		!st_ff.fail_safe;

	// Per-channel fault terms
	for (genvar g = 0; g < 2; g++) begin : g_term
		assign rcond_w[g] = over_current[g] | severe_short[g] |
			over_temperature[g] | under_voltage;
		assign hold_w[g] = over_temperature[g] | under_voltage;
		assign en_w[g] = st_ff.chan[g].retry_sel == load_type_select[g];
		assign clr_w[g] = fs_entry_w | wake_evt_w | por_evt_w |
			st_ff.chan[g].unlimited |
			(wr_do && wsel == (g ? FAR_SEL_CH1 : FAR_SEL_CH0) &&
			st_ff.wstrb[0] && en_w[g] &&
			(st_ff.wdata[`FAR_CFG_RSEL] != load_type_select[g]));
		assign delatch_w[g] = wr_do && st_ff.wstrb[1] &&
			wsel == (g ? FAR_SEL_CH1 : FAR_SEL_CH0) &&
			st_ff.wdata[`FAR_CFG_DELATCH];
	end

	// Next-state logic
	always_comb begin
		far_chan_t ch;
		logic      fsb_low;
		logic      rd_stat;
		logic      rd_flt;
		logic      unl_rise;
		ch       = CH_RST;
		fsb_low  = 1'b0;
		rd_stat  = 1'b0;
		rd_flt   = 1'b0;
		unl_rise = 1'b0;
		nxt_st   = st_ff;
		nxt_st.asleep    = asleep_w;
		nxt_st.vpwr_prev = vpwr_above_por;
		nxt_st.vdd_prev  = vdd_above_por;
		nxt_st.restart   = 2'b00;
		// Write channel: capture address and data, then commit
		if (aw_take) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = axi_req.awaddr;
		end
		if (w_take) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = axi_req.wdata;
			nxt_st.wstrb = axi_req.wstrb;
		end
		if (wr_do) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = `FAR_RESP_OKAY;
			case (wsel)
				FAR_SEL_GEN: begin
					if (st_ff.wstrb[0])
						nxt_st.supply_loss_en = st_ff.wdata[0];
				end
				FAR_SEL_CH0, FAR_SEL_CH1: begin
					ch = nxt_st.chan[wsel == FAR_SEL_CH1];
					if (st_ff.wstrb[0]) begin
						ch.retry_sel = st_ff.wdata[`FAR_CFG_RSEL];
						ch.unlimited = st_ff.wdata[`FAR_CFG_UNL];
						ch.period    = st_ff.wdata[`FAR_CFG_PER_LO +: 2];
						ch.os_dis    = st_ff.wdata[`FAR_CFG_OS_DIS];
						ch.open_load_off_flag_dis = st_ff.wdata[`FAR_CFG_OLF_DIS];
					end
					if (st_ff.wstrb[1])
						ch.open_load_on_flag_dis = st_ff.wdata[`FAR_CFG_OLN_DIS];
					nxt_st.chan[wsel == FAR_SEL_CH1] = ch;
				end
				default: nxt_st.bresp = `FAR_RESP_SLVERR;
			endcase
		end else if (st_ff.bvalid && axi_req.bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Read channel: answer one cycle after the address is taken
		if (ar_take) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rdata  = far_rd(st_ff, rsel);
			nxt_st.rresp  = (rsel == FAR_SEL_NONE) ?
				`FAR_RESP_SLVERR : `FAR_RESP_OKAY;
			rd_stat = rsel == FAR_SEL_STAT;
			rd_flt  = rsel == FAR_SEL_FLT;
		end else if (st_ff.rvalid && axi_req.rready) begin
			nxt_st.rvalid = 1'b0;
		end
		// Fail-safe entry clears the serial registers; undervoltage does not
		if (fs_entry_w) begin
			nxt_st.fail_safe      = 1'b1;
			nxt_st.supply_loss_en = 1'b0;
			nxt_st.por            = 1'b0;
			nxt_st.uv             = 1'b0;
		end else if (!logic_supply_fail) begin
			nxt_st.fail_safe = 1'b0;
		end
		// Power-on flag: read clears, a new event wins
		if (rd_stat)
			nxt_st.por = 1'b0;
		if (por_evt_w)
			nxt_st.por = 1'b1;
		if (rd_flt && !under_voltage)
			nxt_st.uv = 1'b0;
		if (under_voltage)
			nxt_st.uv = 1'b1;
		// Per-channel supervision
		for (int i = 0; i < 2; i++) begin
			ch = nxt_st.chan[i];
			unl_rise = ch.unlimited && !st_ff.chan[i].unlimited;
			if (fs_entry_w)
				ch = CH_RST;
			// Clear-on-read of the fault word
			if (rd_flt) begin
				if (ch.state != FAR_LATCH) begin
					if (!over_current[i])
						ch.oc = 1'b0;
					if (!severe_short[i])
						ch.sc = 1'b0;
					if (!over_temperature[i])
						ch.ot = 1'b0;
				end
				ch.os    = 1'b0;
				ch.open_load_off_flag = 1'b0;
				if (!open_load_on_det[i])
					ch.open_load_on_flag = 1'b0;
			end
			// Sticky fault capture, sets win over clears
			ch.oc = ch.oc | over_current[i];
			ch.sc = ch.sc | severe_short[i];
			ch.ot = ch.ot | over_temperature[i];
			// Diagnostics flag only, never switch the channel
			if (!st_ff.chan_on[i]) begin
				if (out_above_short_thr[i] && !st_ff.chan[i].os_dis) begin
					ch.os   = 1'b1;
					fsb_low = 1'b1;
				end
				if (out_above_openload_thr[i] && !st_ff.chan[i].open_load_off_flag_dis) begin
					ch.open_load_off_flag = 1'b1;
					fsb_low  = 1'b1;
				end
			end else if (open_load_on_det[i] && !st_ff.chan[i].open_load_on_flag_dis) begin
				ch.open_load_on_flag = 1'b1;
				fsb_low = 1'b1;
			end
			// Retry state machine
			case (ch.state)
				FAR_ON: begin
					if (rcond_w[i]) begin
						ch.fault_control = 1'b1;
						if (!en_w[i] || (!ch.unlimited && ch.final_used)) begin
							ch.state = FAR_LATCH;
						end else begin
							ch.state = FAR_WAIT;
							ch.timer = far_period(ch.period);
						end
					end
				end
				FAR_WAIT: begin
					if (delatch_w[i]) begin
						ch.state         = FAR_ON;
						ch.fault_control = 1'b0;
					end else if (!en_w[i]) begin
						ch.state = FAR_LATCH;
					end else if (!hold_w[i]) begin
						if (ch.timer <= 24'h000001) begin
							ch.state         = FAR_ON;
							ch.fault_control = 1'b0;
							ch.restart_pending = 1'b1;
							ch.oc_in_period  = 1'b0;
							if (!load_type_select[i])
								nxt_st.restart[i] = 1'b1;
							if (!ch.unlimited) begin
								if (ch.cnt == `FAR_CNT_MAX) begin
									ch.final_used = 1'b1;
								end else begin
									ch.cnt = ch.cnt + 4'h1;
									if (ch.cnt == `FAR_CNT_MAX)
										ch.rfull = 1'b1;
								end
							end
						end else begin
							ch.timer = ch.timer - 24'h000001;
						end
					end
				end
				FAR_LATCH: begin
					if (delatch_w[i]) begin
						ch.state         = FAR_ON;
						ch.fault_control = 1'b0;
					end else if (unl_rise && en_w[i]) begin
						ch.state = FAR_WAIT;
						ch.timer = far_period(ch.period);
					end
				end
				default: ch.state = FAR_ON;
			endcase
			// Counter clears, including unlimited taking effect at once
			if (clr_w[i] || ch.unlimited) begin
				ch.cnt        = 4'h0;
				ch.rfull      = 1'b0;
				ch.final_used = 1'b0;
			end
			// Motor mode duration restart at first clean period end
			if (over_current[i])
				ch.oc_in_period = 1'b1;
			if (pwm_period_end[i]) begin
				if (load_type_select[i] && ch.restart_pending &&
					!ch.oc_in_period)
					nxt_st.restart[i] = 1'b1;
				if (!ch.oc_in_period)
					ch.restart_pending = 1'b0;
				ch.oc_in_period = 1'b0;
			end
			if (rcond_w[i] || ch.state != FAR_ON)
				fsb_low = 1'b1;
			nxt_st.chan_on[i] = nxt_st.fail_safe ? direct_in[i] :
				(ch.state == FAR_ON && channel_request[i]);
			nxt_st.chan[i] = ch;
		end
		nxt_st.fsb_n = !fsb_low;
	end

	// State register; the bus keeps working through undervoltage
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst)
			st_ff <= ST_RST;
		else
			st_ff <= nxt_st;
	end

	// Outputs
	assign axi_rsp.awready = !st_ff.aw_got && !st_ff.bvalid;
	assign axi_rsp.wready  = !st_ff.w_got && !st_ff.bvalid;
	assign axi_rsp.bvalid  = st_ff.bvalid;
	assign axi_rsp.bresp   = st_ff.bresp;
	assign axi_rsp.arready = !st_ff.rvalid;
	assign axi_rsp.rvalid  = st_ff.rvalid;
	assign axi_rsp.rdata   = st_ff.rdata;
	assign axi_rsp.rresp   = st_ff.rresp;
	assign channel_on          = st_ff.chan_on;
	assign oc_duration_restart = st_ff.restart;
	assign fault_status_n      = st_ff.fsb_n;
	assign fail_safe           = st_ff.fail_safe;

	// Checks on channel 0, and on channel 1 where the bench drives it
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	property p_fs_direct;
		(st_ff.fail_safe && logic_supply_fail) |=> channel_on == $past(direct_in);
	endproperty
	a_fs_direct: assert property (p_fs_direct)
		else $error("fail-safe does not follow direct inputs");

	property p_diag_no_off;
		(st_ff.chan[0].state == FAR_ON && !rcond_w[0])
			|=> st_ff.chan[0].state == FAR_ON;
	endproperty
	a_diag_no_off: assert property (p_diag_no_off)
		else $error("channel left on state without retry condition");

	property p_por_rise;
		(vpwr_above_por && !st_ff.vpwr_prev && !vdd_above_por &&
			!st_ff.vdd_prev) |=> st_ff.por;
	endproperty
	a_por_rise: assert property (p_por_rise)
		else $error("power-on flag not set on supply rise");

	property p_por_wake;
		(wake_evt_w && vdd_above_por && st_ff.vdd_prev) |=> st_ff.por;
	endproperty
	a_por_wake: assert property (p_por_wake)
		else $error("power-on flag not set on wake");

	property p_latch_dis;
		(st_ff.chan[1].state == FAR_ON && rcond_w[1] && !en_w[1] &&
			!fs_entry_w) |=> st_ff.chan[1].state == FAR_LATCH;
	endproperty
	a_latch_dis: assert property (p_latch_dis)
		else $error("fault with retry disabled did not latch");

	property p_retry_expire;
		(st_ff.chan[0].state == FAR_WAIT && st_ff.chan[0].timer == 24'h000001
			&& !hold_w[0] && !delatch_w[0] && en_w[0] && !fs_entry_w)
			|=> st_ff.chan[0].state == FAR_ON;
	endproperty
	a_retry_expire: assert property (p_retry_expire)
		else $error("channel not back on after retry period");

	property p_unl_no_latch;
		(st_ff.chan[0].unlimited && en_w[0] &&
			st_ff.chan[0].state != FAR_LATCH)
			|=> st_ff.chan[0].state != FAR_LATCH;
	endproperty
	a_unl_no_latch: assert property (p_unl_no_latch)
		else $error("unlimited retry latched the channel");

	property p_rfull;
		$rose(st_ff.chan[0].cnt == `FAR_CNT_MAX) |-> st_ff.chan[0].rfull;
	endproperty
	a_rfull: assert property (p_rfull)
		else $error("exhausted bit not set at counter maximum");

	property p_delatch;
		(st_ff.chan[0].state == FAR_WAIT && delatch_w[0] && !clr_w[0])
			|=> (st_ff.chan[0].state == FAR_ON &&
			st_ff.chan[0].cnt == $past(st_ff.chan[0].cnt));
	endproperty
	a_delatch: assert property (p_delatch)
		else $error("delatch failed or changed the counter");

	property p_cnt_clr;
		clr_w[0] |=> st_ff.chan[0].cnt == 4'h0;
	endproperty
	a_cnt_clr: assert property (p_cnt_clr)
		else $error("retry counter not cleared");

	property p_short_live;
		(!channel_on[1] && out_above_short_thr[1] && !st_ff.chan[1].os_dis)
			|=> !fault_status_n;
	endproperty
	a_short_live: assert property (p_short_live)
		else $error("off-state short not shown on fault output");

endmodule : far_core

// ### testbench/far_host_model.sv
// Register bus master that stands in for the host controller
module far_host_model (
	// Clock
	input  wire logic             core_clk,
	// Register bus
	output far_pkg::far_axi_req_t axi_req,
	input  far_pkg::far_axi_rsp_t axi_rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	import far_pkg::*;

	// Bus idle from time zero
	initial axi_req = '0;

	// One write; each channel is released at the edge that takes it
	task automatic wr(input logic [31:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge core_clk);
		axi_req.awaddr  <= a;
		axi_req.wdata   <= d;
		axi_req.wstrb   <= 4'hF;
		axi_req.awvalid <= 1'b1;
		axi_req.wvalid  <= 1'b1;
		axi_req.bready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
		end while (axi_rsp.bvalid !== 1'b1);
		r = axi_rsp.bresp;
		axi_req.bready <= 1'b0;
	endtask : wr

	// One read; rready held until the answer is sampled
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge core_clk);
		axi_req.araddr  <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
		end while (axi_rsp.rvalid !== 1'b1);
		d = axi_rsp.rdata;
		r = axi_rsp.rresp;
		axi_req.rready <= 1'b0;
	endtask : rd
endmodule : far_host_model

// ### testbench/fault_autoretry_diagnostics_tb.sv
// Self-checking bench of the fault supervision and auto-retry block
`include "far_consts.svh"
module fault_autoretry_diagnostics_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import far_pkg::*;

	logic          core_clk, sys_rst, logic_supply_fail, vpwr_above_por;
	logic          vdd_above_por, wake_reset_n, under_voltage;
	logic          fault_status_n, fail_safe, on_q;
	logic [1:0]    direct_in, channel_request, load_type_select;
	logic [1:0]    over_current, severe_short, over_temperature;
	logic [1:0]    open_load_on_det, out_above_short_thr;
	logic [1:0]    out_above_openload_thr, pwm_period_end;
	logic [1:0]    channel_on, oc_duration_restart;
	far_axi_req_t  axi_req;
	far_axi_rsp_t  axi_rsp;
	int            n_errors, n_tests, n_rise, n_rst;

	far_core #(.RETRY_CYC0(24'h8), .RETRY_CYC1(24'hC),
		.RETRY_CYC2(24'h10), .RETRY_CYC3(24'h14)) DUT (
		.core_clk, .sys_rst, .axi_req, .axi_rsp, .logic_supply_fail,
		.vpwr_above_por, .vdd_above_por, .wake_reset_n, .under_voltage,
		.direct_in, .channel_request, .load_type_select, .over_current,
		.severe_short, .over_temperature, .open_load_on_det,
		.out_above_short_thr, .out_above_openload_thr, .pwm_period_end,
		.channel_on, .oc_duration_restart, .fault_status_n, .fail_safe);

	far_host_model host (.core_clk, .axi_req, .axi_rsp);

	// Clock
	initial core_clk = 1'b0;
	always #5 core_clk = ~core_clk;

	// Counts switch-ons under fault and duration restarts of channel 0
	always @(posedge core_clk) begin
		if (channel_on[0] && !on_q && over_current[0]) n_rise++;
		if (oc_duration_restart[0] === 1'b1) n_rst++;
		on_q = channel_on[0];
	end

	// Watchdog against a hung handshake
	initial begin
		#100us;
		n_errors++;
		test_done();
	end

	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wrc(input logic [31:0] a, input logic [31:0] d);
		logic [1:0] r;
		host.wr(a, d, r);
		chk("bresp", r, 2'b00);
	endtask : wrc

	// Read, mask and compare
	task automatic rdc(input logic [31:0] a, input logic [31:0] e,
		input logic [31:0] m, input string nm);
		logic [31:0] d;
		logic [1:0]  r;
		host.rd(a, d, r);
		chk(nm, d & m, e);
	endtask : rdc

	task automatic test_done;
		$display("Checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		{direct_in, channel_request, load_type_select, over_current} = '0;
		{severe_short, over_temperature, open_load_on_det} = '0;
		{out_above_short_thr, out_above_openload_thr, pwm_period_end} = '0;
		{logic_supply_fail, under_voltage} = '0;
		{vpwr_above_por, vdd_above_por} = 2'b00;
		wake_reset_n = 1'b1;
		sys_rst = 1'b1;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		chk("reset", {channel_on, fail_safe, fault_status_n}, 32'h1);
		// Power supply rises first, logic supply follows
		vpwr_above_por <= 1'b1;
		@(posedge core_clk);
		vdd_above_por <= 1'b1;
		repeat (2) @(posedge core_clk);
		rdc(`FAR_ADDR_STAT, 32'h40, 32'h40, "por");
		// Logic supply alone rising, then a wake from sleep
		{vpwr_above_por, vdd_above_por} <= 2'b00;
		repeat (2) @(posedge core_clk);
		vdd_above_por <= 1'b1;
		repeat (2) @(posedge core_clk);
		rdc(`FAR_ADDR_STAT, 32'h40, 32'h40, "por_vdd");
		{vpwr_above_por, wake_reset_n} <= 2'b10;
		repeat (2) @(posedge core_clk);
		wake_reset_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rdc(`FAR_ADDR_STAT, 32'h40, 32'h40, "por_wake");
		host.rd(32'h4, d, r);
		chk("unmapped", r, 2'b10);
		host.wr(`FAR_ADDR_STAT, 32'h1, r);
		chk("ro_write", r, 2'b10);
		// Off-state short and open load, each enabled then disabled
		for (int k = 0; k < 4; k++) begin
			wrc(`FAR_ADDR_CH1, (k % 2) << (6 + k / 2));
			{out_above_openload_thr[1], out_above_short_thr[1]}
				<= 2'(1 << (k / 2));
			repeat (2) @(posedge core_clk);
			chk("live", fault_status_n, k % 2);
			{out_above_openload_thr[1], out_above_short_thr[1]} <= 2'b00;
			repeat (2) @(posedge core_clk);
			chk("clear", fault_status_n, 1);
			rdc(`FAR_ADDR_FLT, (1 - k % 2) << (11 + k / 2), 32'h1800,
				"sticky");
		end
		// Lamp channel with limited retry until it latches
		channel_request[0] <= 1'b1;
		repeat (2) @(posedge core_clk);
		over_current[0] <= 1'b1;
		wrc(`FAR_ADDR_CH0, 32'h200);
		for (int i = 0; i < 200; i++) begin
			host.rd(`FAR_ADDR_STAT, d, r);
			if (d[0] === 1'b1) break;
		end
		chk("retries", n_rise, 17);
		chk("restart", n_rst, 16);
		chk("fsb_latch", fault_status_n, 0);
		rdc(`FAR_ADDR_STAT, 32'h11, 32'h11, "exhaust");
		rdc(`FAR_ADDR_CH0, 32'hF0, 32'hFF, "count");
		// Unlimited bit clears the counter and retries the latched channel
		wrc(`FAR_ADDR_CH0, 32'h2);
		repeat (2) @(posedge core_clk);
		rdc(`FAR_ADDR_CH0, 32'h02, 32'hFF, "unl");
		over_current[0] <= 1'b0;
		for (int i = 0; i < 100 && channel_on[0] !== 1'b1; i++)
			@(posedge core_clk);
		chk("resume", channel_on[0], 1);
		chk("fsb_ok", fault_status_n, 1);
		rdc(`FAR_ADDR_FLT, 32'h1, 32'h1, "oc_bit");
		// Motor channel with retry disabled latches at once
		load_type_select[1] <= 1'b1;
		channel_request[1]  <= 1'b1;
		repeat (2) @(posedge core_clk);
		{severe_short[1], over_temperature[1]} <= 2'b11;
		repeat (2) @(posedge core_clk);
		chk("latch", channel_on[1], 0);
		rdc(`FAR_ADDR_STAT, 32'h2, 32'h2, "latched");
		{severe_short[1], over_temperature[1]} <= 2'b00;
		// Undervoltage holds the retry; the bus keeps answering
		under_voltage <= 1'b1;
		repeat (12) @(posedge core_clk);
		chk("uv_hold", channel_on[0], 0);
		rdc(`FAR_ADDR_FLT, 32'h10000, 32'h10000, "uv_bit");
		under_voltage <= 1'b0;
		repeat (12) @(posedge core_clk);
		chk("uv_retry", channel_on[0], 1);
		// Fail-safe on logic-supply loss
		wrc(`FAR_ADDR_GEN, 32'h1);
		direct_in         <= 2'b10;
		logic_supply_fail <= 1'b1;
		repeat (2) @(posedge core_clk);
		chk("failsafe", {fail_safe, channel_on}, 3'b110);
		logic_supply_fail <= 1'b0;
		repeat (2) @(posedge core_clk);
		rdc(`FAR_ADDR_CH0, 32'h0, 32'hFF, "fs_clear");
		rdc(`FAR_ADDR_GEN, 32'h0, 32'h1, "gen_clear");
		test_done();
	end
endmodule : fault_autoretry_diagnostics_tb
